// ### compact_timer_cfg.svh
`ifndef COMPACT_TIMER_CFG_SVH
`define COMPACT_TIMER_CFG_SVH

// Register indices on the plain port
`define CT_ADDR_CTRL_A 3'h0
`define CT_ADDR_CTRL_B 3'h1
`define CT_ADDR_CNT_LO 3'h2
`define CT_ADDR_CNT_HI 3'h3
`define CT_ADDR_CMPA_LO 3'h4
`define CT_ADDR_CMPA_HI 3'h5

// Control A field positions
`define CT_A_PAUSE 7
`define CT_A_CLK_HI 6
`define CT_A_CLK_LO 4
`define CT_A_ON 3
`define CT_A_PER_HI 2
`define CT_A_PER_LO 0

// Control B field positions
`define CT_B_MODE_HI 7
`define CT_B_MODE_LO 6
`define CT_B_FUNC_HI 5
`define CT_B_FUNC_LO 4
`define CT_B_OC 3
`define CT_B_POL 2
`define CT_B_DPX 1
`define CT_B_CCLR 0

// Reset values
`define CT_CTRL_A_RST 8'h00
`define CT_CTRL_B_RST 8'h00
`define CT_CNT_RST 10'h000
`define CT_CMPA_RST 10'h000

// Prescale counts
`define CT_DIV_SYS4 6'h03
`define CT_DIV_H16 6'h0f
`define CT_DIV_H64 6'h3f

`endif

// ### compact_timer_pkg.sv
package compact_timer_pkg;
	typedef enum logic [2:0] {
		CLK_SYS_DIV4 = 3'h0,
		CLK_SYS = 3'h1,
		CLK_H_DIV16 = 3'h2,
		CLK_H_DIV64 = 3'h3,
		CLK_SUB_A = 3'h4,
		CLK_SUB_B = 3'h5,
		CLK_PIN_RISE = 3'h6,
		CLK_PIN_FALL = 3'h7
	} clk_sel_e;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'h0,
		MODE_RSVD = 2'h1,
		MODE_PWM = 2'h2,
		MODE_TIMER = 2'h3
	} op_mode_e;

	// One-hot state of the counter run control
	typedef enum logic [2:0] {
		RUN_OFF = 3'b001,
		RUN_ACTIVE = 3'b010,
		RUN_PAUSED = 3'b100
	} run_state_e;
endpackage : compact_timer_pkg

// ### count_tick_gen.sv
`timescale 1ns/100ps
`include "compact_timer_cfg.svh"

// Turns the selected source into a one-cycle count enable
module count_tick_gen (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Source select and strobes
	input wire compact_timer_pkg::clk_sel_e sel_in,
	input wire logic high_clk_tick_in,
	input wire logic sub_clk_tick_in,
	input wire logic ext_pin_in,
	// Count enable
	output logic tick_out
);
	import compact_timer_pkg::*;

	logic [5:0] sys_div_r;
	logic [5:0] h_div_r;
	logic pin_prev_r;
	logic tick_nxt;

	// Free-running prescalers
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sys_div_r <= 6'h00;
			h_div_r <= 6'h00;
		end else begin
			sys_div_r <= (sys_div_r == `CT_DIV_SYS4) ? 6'h00 : sys_div_r + 6'h01;
			if (high_clk_tick_in) begin
				h_div_r <= h_div_r + 6'h01;
			end
		end
	end

	// Pin history for edge detection
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pin_prev_r <= 1'b0;
		end else begin
			pin_prev_r <= ext_pin_in;
		end
	end

	// Source mux
	always_comb begin
		case (sel_in)
			CLK_SYS_DIV4: tick_nxt = (sys_div_r == `CT_DIV_SYS4);
			CLK_SYS: tick_nxt = 1'b1;
			CLK_H_DIV16: tick_nxt = high_clk_tick_in && ((h_div_r & `CT_DIV_H16) == `CT_DIV_H16);
			CLK_H_DIV64: tick_nxt = high_clk_tick_in && (h_div_r == `CT_DIV_H64);
			CLK_SUB_A, CLK_SUB_B: tick_nxt = sub_clk_tick_in;
			CLK_PIN_RISE: tick_nxt = ext_pin_in && !pin_prev_r;
			CLK_PIN_FALL: tick_nxt = !ext_pin_in && pin_prev_r;
			default: tick_nxt = 1'b0;
		endcase
	end

	// Registered so the enable is glitch free
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= tick_nxt;
		end
	end
endmodule : count_tick_gen

// ### byte_pair_buffer.sv
`timescale 1ns/100ps

// Shared low-byte staging buffer for split 10-bit registers
module byte_pair_buffer (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Load controls
	input wire logic load_in,
	input wire logic [7:0] load_data_in,
	// Buffered byte
	output logic [7:0] data_out
);
	// Holds staged write data or latched read data
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			data_out <= 8'h00;
		end else if (load_in) begin
			data_out <= load_data_in;
		end
	end
endmodule : byte_pair_buffer

// ### compact_timer.sv
`timescale 1ns/100ps
`include "compact_timer_cfg.svh"

module compact_timer (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Count sources
	input wire logic high_clk_tick_in,
	input wire logic sub_clk_tick_in,
	input wire logic external_count_pin_in,
	// Flag acknowledge from the interrupt controller
	input wire logic compare_a_flag_clr_in,
	input wire logic period_flag_clr_in,
	// Outputs
	output logic timer_output_pin_out,
	output logic compare_a_match_flag_out,
	output logic period_match_flag_out
);
	import compact_timer_pkg::*;

	// Software-visible registers and run state
	logic [7:0] timer_control_a_r;
	logic [7:0] timer_control_b_r;
	logic [9:0] count_r;
	logic [9:0] compare_a_value_r;
	// Nets between this module and its two helpers, then the on-bit history and pin level registers
	logic [7:0] buf_data;
	logic buf_load;
	logic [7:0] buf_load_data;
	logic tick;
	logic on_prev_r;
	logic pin_level_r;
	// One-hot run state kept beside the raw on bit
	run_state_e run_state_r;
	run_state_e run_state_nxt;

	// Control fields
	// Nets named after the register bits they slice
	logic counter_on_bit;
	logic counter_pause_bit;
	logic [2:0] period_match_bits;
	op_mode_e operating_mode_field;
	logic [1:0] output_function_field;
	logic output_control_bit;
	logic output_polarity_bit;
	logic period_duty_select;
	logic clear_select_bit;
	clk_sel_e count_clock_select;

	// Field slices; positions live in the config header
	assign counter_on_bit = timer_control_a_r[`CT_A_ON];
	assign counter_pause_bit = timer_control_a_r[`CT_A_PAUSE];
	assign period_match_bits = timer_control_a_r[`CT_A_PER_HI:`CT_A_PER_LO];
	assign count_clock_select = clk_sel_e'(timer_control_a_r[`CT_A_CLK_HI:`CT_A_CLK_LO]);
	assign operating_mode_field = op_mode_e'(timer_control_b_r[`CT_B_MODE_HI:`CT_B_MODE_LO]);
	assign output_function_field = timer_control_b_r[`CT_B_FUNC_HI:`CT_B_FUNC_LO];
	assign output_control_bit = timer_control_b_r[`CT_B_OC];
	assign output_polarity_bit = timer_control_b_r[`CT_B_POL];
	assign period_duty_select = timer_control_b_r[`CT_B_DPX];
	assign clear_select_bit = timer_control_b_r[`CT_B_CCLR];

	// Count enable source
	// Registered enable adds one cycle between source edge and count
	count_tick_gen u_tick (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.sel_in(count_clock_select),
		.high_clk_tick_in(high_clk_tick_in),
		.sub_clk_tick_in(sub_clk_tick_in),
		.ext_pin_in(external_count_pin_in),
		.tick_out(tick)
	);

	// Shared staging byte: loaded by compare A low writes and high reads
	// A high read and a low write never share a cycle, so one
	// byte of storage serves both register pairs
	assign buf_load = (reg_wr_in && (reg_addr_in == `CT_ADDR_CMPA_LO)) ||
		(reg_rd_in && ((reg_addr_in == `CT_ADDR_CNT_HI) ||
		(reg_addr_in == `CT_ADDR_CMPA_HI)));
	always_comb begin
		if (reg_wr_in) begin
			buf_load_data = reg_wdata_in;
		end else if (reg_addr_in == `CT_ADDR_CNT_HI) begin
			buf_load_data = count_r[7:0];
		end else begin
			buf_load_data = compare_a_value_r[7:0];
		end
	end

	byte_pair_buffer u_buf (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.load_in(buf_load),
		.load_data_in(buf_load_data),
		.data_out(buf_data)
	);

	// Control register writes
	// Mode and field changes act the cycle after the write;
	// software is expected to switch the counter off first
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			timer_control_a_r <= `CT_CTRL_A_RST;
			timer_control_b_r <= `CT_CTRL_B_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `CT_ADDR_CTRL_A) begin
				timer_control_a_r <= reg_wdata_in;
			end else if (reg_addr_in == `CT_ADDR_CTRL_B) begin
				timer_control_b_r <= reg_wdata_in;
			end
		end
	end

	// Compare A: high write commits the staged low byte
	// A lone low write only stages; the pair updates at once
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			compare_a_value_r <= `CT_CMPA_RST;
		end else if (reg_wr_in && (reg_addr_in == `CT_ADDR_CMPA_HI)) begin
			compare_a_value_r <= {reg_wdata_in[1:0], buf_data};
		end
	end

	// Read mux; low bytes come from the staging buffer
	// Idle cycles read zero so stale data never lingers
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			if (reg_addr_in == `CT_ADDR_CTRL_A) begin
				reg_rdata_out <= timer_control_a_r;
			end else if (reg_addr_in == `CT_ADDR_CTRL_B) begin
				reg_rdata_out <= timer_control_b_r;
			end else if (reg_addr_in == `CT_ADDR_CNT_LO) begin
				reg_rdata_out <= buf_data;
			end else if (reg_addr_in == `CT_ADDR_CNT_HI) begin
				reg_rdata_out <= {6'h00, count_r[9:8]};
			end else if (reg_addr_in == `CT_ADDR_CMPA_LO) begin
				reg_rdata_out <= buf_data;
			end else if (reg_addr_in == `CT_ADDR_CMPA_HI) begin
				reg_rdata_out <= {6'h00, compare_a_value_r[9:8]};
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

	// Run control state
	always_comb begin
		case (run_state_r)
			RUN_OFF: run_state_nxt = counter_on_bit ? RUN_ACTIVE : RUN_OFF;
			RUN_ACTIVE: begin
				if (!counter_on_bit) begin
					run_state_nxt = RUN_OFF;
				end else if (counter_pause_bit) begin
					run_state_nxt = RUN_PAUSED;
				end else begin
					run_state_nxt = RUN_ACTIVE;
				end
			end
			RUN_PAUSED: begin
				if (!counter_on_bit) begin
					run_state_nxt = RUN_OFF;
				end else if (!counter_pause_bit) begin
					run_state_nxt = RUN_ACTIVE;
				end else begin
					run_state_nxt = RUN_PAUSED;
				end
			end
			default: run_state_nxt = RUN_OFF;
		endcase
	end

	// State and on-bit history; history drives the switch-on clear
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			run_state_r <= RUN_OFF;
			on_prev_r <= 1'b0;
		end else begin
			run_state_r <= run_state_nxt;
			on_prev_r <= counter_on_bit;
		end
	end

	// Match detection
	logic on_rise;
	logic counting;
	logic is_pwm;
	logic per_hit;
	logic a_hit;
	logic at_top;
	logic per_zero;
	logic a_zero;
	logic clear_count;
	logic set_a_flag;
	logic set_p_flag;

	// Counting needs the active state, so a resume waits one cycle
	// after the pause bit falls; the cost of a registered state
	assign on_rise = counter_on_bit && !on_prev_r;
	assign counting = (run_state_r == RUN_ACTIVE) && counter_on_bit && !counter_pause_bit && tick;
	assign is_pwm = (operating_mode_field == MODE_PWM);
	assign per_zero = (period_match_bits == 3'h0);
	assign a_zero = (compare_a_value_r == 10'h000);
	assign at_top = (count_r == 10'h3ff);
	// Period bits of zero mean the full 10-bit range
	// Match falls on the last count of the 128-count block numbered period bits minus one
	assign per_hit = per_zero ? at_top :
		((count_r[9:7] == period_match_bits - 3'h1) && (count_r[6:0] == 7'h7f));
	// Matching one count early lets the clear land on the match value,
	// so the period is exactly the programmed count
	assign a_hit = !a_zero && (count_r + 10'h001 == compare_a_value_r);

	// Clear source per mode and clear select
	// PWM ignores clear select; the role bit picks the clearing compare
	always_comb begin
		if (is_pwm) begin
			clear_count = period_duty_select ? (a_hit || (a_zero && at_top)) : per_hit;
		end else if (clear_select_bit) begin
			clear_count = a_hit || at_top;
		end else begin
			clear_count = per_hit;
		end
	end

	// Flags follow the counting edge, so a paused counter raises none
	assign set_a_flag = counting && a_hit;
	// Clear on A suppresses the period flag outside PWM
	assign set_p_flag = counting && per_hit && (is_pwm || !clear_select_bit);

	// Counter
	// Switch-on clear outranks counting so the first tick gives one
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			count_r <= `CT_CNT_RST;
		end else if (on_rise) begin
			count_r <= 10'h000;
		end else if (counting) begin
			count_r <= clear_count ? 10'h000 : count_r + 10'h001;
		end
	end

	// Flags: a set in the clearing cycle wins
	// Clear inputs are pulses from whoever services the flag
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			compare_a_match_flag_out <= 1'b0;
			period_match_flag_out <= 1'b0;
		end else begin
			compare_a_match_flag_out <= set_a_flag || (compare_a_match_flag_out && !compare_a_flag_clr_in);
			period_match_flag_out <= set_p_flag || (period_match_flag_out && !period_flag_clr_in);
		end
	end

	// Compare-mode pin level before polarity
	// Matches move it and it drives the pin only in compare
	// mode; a switch-on always reloads the initial level
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pin_level_r <= 1'b0;
		end else if (on_rise) begin
			pin_level_r <= output_control_bit;
		end else if (set_a_flag && (operating_mode_field == MODE_COMPARE)) begin
			case (output_function_field)
				2'h1: pin_level_r <= 1'b0;
				2'h2: pin_level_r <= 1'b1;
				2'h3: pin_level_r <= !pin_level_r;
				default: pin_level_r <= pin_level_r;
			endcase
		end
	end

	// PWM duty compare; duty at or past period saturates high
	// Widened by a bit so a limit of 1024 still fits
	// Counter at or past the limit gives the inactive level
	logic pwm_active;
	logic [10:0] duty_lim;
	always_comb begin
		if (period_duty_select) begin
			duty_lim = per_zero ? 11'h400 : {1'b0, period_match_bits, 7'h00};
		end else begin
			duty_lim = {1'b0, compare_a_value_r};
		end
		pwm_active = ({1'b0, count_r} < duty_lim);
	end

	// Pin output; timer mode holds the pin low whether the counter is on or off
	// Reserved mode 01 also parks the pin low
	// PWM code 11 is undefined, so the pin keeps its level
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			timer_output_pin_out <= 1'b0;
		end else begin
			case (operating_mode_field)
				MODE_COMPARE: timer_output_pin_out <= pin_level_r ^ output_polarity_bit;
				MODE_PWM: begin
					case (output_function_field)
						2'h0: timer_output_pin_out <= !output_control_bit ^ output_polarity_bit;
						2'h1: timer_output_pin_out <= output_control_bit ^ output_polarity_bit;
						2'h2: timer_output_pin_out <=
							((pwm_active == output_control_bit)) ^ output_polarity_bit;
						default: timer_output_pin_out <= timer_output_pin_out;
					endcase
				end
				default: timer_output_pin_out <= 1'b0;
			endcase
		end
	end
endmodule : compact_timer

// ### compact_timer_chk.sv
`timescale 1ns/100ps
`include "compact_timer_cfg.svh"

// Port-level watch on the register port, flags and pin
module compact_timer_chk (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// Flags and pin
	input wire logic compare_a_flag_clr_in,
	input wire logic period_flag_clr_in,
	input wire logic timer_output_pin_out,
	input wire logic compare_a_match_flag_out,
	input wire logic period_match_flag_out
);
	logic [7:0] ctrl_a_r;
	logic [7:0] ctrl_b_r;
	logic [1:0] quiet_r;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	// Shadow of the control registers as written
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl_a_r <= 8'h00;
			ctrl_b_r <= 8'h00;
		end else if (reg_wr_in && reg_addr_in == `CT_ADDR_CTRL_A) begin
			ctrl_a_r <= reg_wdata_in;
		end else if (reg_wr_in && reg_addr_in == `CT_ADDR_CTRL_B) begin
			ctrl_b_r <= reg_wdata_in;
		end
	end

	// Cycles since a mode write; the pin pipeline needs three to settle
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			quiet_r <= 2'h0;
		end else if (reg_wr_in && reg_addr_in == `CT_ADDR_CTRL_B) begin
			quiet_r <= 2'h0;
		end else if (quiet_r != 2'h3) begin
			quiet_r <= quiet_r + 2'h1;
		end
	end

	sequence s_on_rise;
		reg_wr_in && reg_addr_in == `CT_ADDR_CTRL_A && reg_wdata_in[`CT_A_ON] &&
			!ctrl_a_r[`CT_A_ON] && ctrl_b_r[7:6] == 2'h0;
	endsequence
	sequence s_pin_initial;
		##[2:4] timer_output_pin_out == (ctrl_b_r[`CT_B_OC] ^ ctrl_b_r[`CT_B_POL]);
	endsequence

	property p_on_rise; s_on_rise |-> s_pin_initial; endproperty
	a_on_rise: assert property (p_on_rise) else $error("pin not at initial level");
	property p_cnt_hi; reg_rd_in && reg_addr_in == `CT_ADDR_CNT_HI |=> reg_rdata_out[7:2] == 6'h00;
	endproperty
	a_cnt_hi: assert property (p_cnt_hi) else $error("counter high upper bits set");
	property p_cmpa_hi; reg_rd_in && reg_addr_in == `CT_ADDR_CMPA_HI |=> reg_rdata_out[7:2] == 6'h00;
	endproperty
	a_cmpa_hi: assert property (p_cmpa_hi) else $error("compare high upper bits set");
	property p_ctrl_a_rb; reg_rd_in && reg_addr_in == `CT_ADDR_CTRL_A |=> reg_rdata_out == $past(ctrl_a_r);
	endproperty
	a_ctrl_a_rb: assert property (p_ctrl_a_rb) else $error("control A readback wrong");
	property p_ctrl_b_rb; reg_rd_in && reg_addr_in == `CT_ADDR_CTRL_B |=> reg_rdata_out == $past(ctrl_b_r);
	endproperty
	a_ctrl_b_rb: assert property (p_ctrl_b_rb) else $error("control B readback wrong");
	property p_a_sticky; compare_a_match_flag_out && !compare_a_flag_clr_in |=> compare_a_match_flag_out;
	endproperty
	a_a_sticky: assert property (p_a_sticky) else $error("compare flag dropped");
	property p_p_sticky; period_match_flag_out && !period_flag_clr_in |=> period_match_flag_out;
	endproperty
	a_p_sticky: assert property (p_p_sticky) else $error("period flag dropped");
	property p_no_period;
		ctrl_b_r[`CT_B_CCLR] && ctrl_b_r[7:6] != 2'h2 && quiet_r == 2'h3 |=> !$rose(period_match_flag_out);
	endproperty
	a_no_period: assert property (p_no_period) else $error("period flag with clear on A");
	property p_timer_pin; ctrl_b_r[7:6] == 2'h3 && quiet_r == 2'h3 |-> !timer_output_pin_out; endproperty
	a_timer_pin: assert property (p_timer_pin) else $error("pin driven in timer mode");
endmodule : compact_timer_chk

bind compact_timer compact_timer_chk compact_timer_chk_inst (.sys_clk_in(sys_clk_in),
	.sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.compare_a_flag_clr_in(compare_a_flag_clr_in), .period_flag_clr_in(period_flag_clr_in),
	.timer_output_pin_out(timer_output_pin_out), .compare_a_match_flag_out(compare_a_match_flag_out),
	.period_match_flag_out(period_match_flag_out));

// ### far_side_model.sv
`timescale 1ns/100ps

// Count sources and a high-time probe on the output pin
module far_side_model (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Probe
	input wire logic meas_clr_in,
	input wire logic timer_output_pin_in,
	// Count sources
	output logic high_clk_tick_out,
	output logic sub_clk_tick_out,
	output logic external_count_pin_out,
	output logic [11:0] high_cnt_out
);
	logic [2:0] phase_r;

	// Ticks every other cycle, pin rises every eighth
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) phase_r <= 3'h0;
		else phase_r <= phase_r + 3'h1;
	end
	assign high_clk_tick_out = phase_r[0];
	assign sub_clk_tick_out = !phase_r[0];
	assign external_count_pin_out = phase_r[2];

	// Pin high time since last clear
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			high_cnt_out <= 12'h000;
		end else if (meas_clr_in) begin
			high_cnt_out <= 12'h000;
		end else if (timer_output_pin_in) begin
			high_cnt_out <= high_cnt_out + 12'h001;
		end
	end
endmodule : far_side_model

// ### testbench.sv
`timescale 1ns/100ps
`include "compact_timer_cfg.svh"

module testbench;
	localparam logic [2:0] adr_ca = `CT_ADDR_CTRL_A;
	localparam logic [2:0] adr_cb = `CT_ADDR_CTRL_B;
	localparam logic [2:0] adr_dh = `CT_ADDR_CNT_HI;
	localparam logic [2:0] adr_ah = `CT_ADDR_CMPA_HI;
	logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
	logic clr_a = 1'b0, clr_p = 1'b0, meas_clr = 1'b0;
	logic [2:0] adr = 3'h0;
	logic [7:0] wd = 8'h00, rdata;
	logic hi_t, sub_t, ext, pin, flag_a, flag_p;
	logic [11:0] high_cnt;
	logic [9:0] v, w;
	int miscompares = 0, n_compared = 0, i, f, n;
	int exp_src[8] = '{64, 256, 8, 2, 128, 128, 32, 32};

	initial forever #25 sys_clk_in = ~sys_clk_in;

	compact_timer compact_timer_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.reg_addr_in(adr), .reg_wdata_in(wd), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
		.reg_rdata_out(rdata), .high_clk_tick_in(hi_t), .sub_clk_tick_in(sub_t),
		.external_count_pin_in(ext), .compare_a_flag_clr_in(clr_a), .period_flag_clr_in(clr_p),
		.timer_output_pin_out(pin), .compare_a_match_flag_out(flag_a),
		.period_match_flag_out(flag_p));
	far_side_model far_side_model_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.meas_clr_in(meas_clr), .timer_output_pin_in(pin), .high_clk_tick_out(hi_t),
		.sub_clk_tick_out(sub_t), .external_count_pin_out(ext), .high_cnt_out(high_cnt));

	task tick(input int k); repeat (k) @(posedge sys_clk_in); endtask : tick
	// One-cycle strobes, changed just after the edge
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		adr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge sys_clk_in);
		wr_s <= 1'b0;
	endtask : wr
	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		adr <= a;
		rd_s <= 1'b1;
		@(posedge sys_clk_in);
		rd_s <= 1'b0;
		@(negedge sys_clk_in);
		d = rdata;
	endtask : rd
	// High first, so the low byte is latched together
	task rd10(input logic [2:0] a, output logic [9:0] q);
		logic [7:0] h, l;
		rd(a, h);
		rd(a - 3'h1, l);
		q = {h[1:0], l};
	endtask : rd10
	task wr_cmpa(input logic [9:0] q);
		wr(adr_ah - 3'h1, q[7:0]);
		wr(adr_ah, {6'h00, q[9:8]});
	endtask : wr_cmpa
	task clr_flags;
		@(posedge sys_clk_in);
		clr_a <= 1'b1;
		clr_p <= 1'b1;
		@(posedge sys_clk_in);
		clr_a <= 1'b0;
		clr_p <= 1'b0;
	endtask : clr_flags
	task wait_flag(input logic p);
		for (n = 0; n < 1200 && (p ? flag_p : flag_a) !== 1'b1; n++) @(negedge sys_clk_in);
	endtask : wait_flag
	function logic [9:0] near(input logic [9:0] a, input int b, input int t);
		return (a + t >= b && a <= b + t) ? 10'h1 : 10'h0;
	endfunction : near
	task check(input logic [9:0] seen, input logic [9:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task results;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results

	// Hang guard, well beyond the few thousand cycles needed
	initial begin
		tick(40000);
		miscompares++;
		results();
	end

	initial begin
		tick(12);
		sys_rst_in <= 1'b0;
		// Reset values, unmapped slots included
		for (i = 0; i < 8; i++) begin
			rd(i[2:0], v[7:0]);
			check(10'(v[7:0]), 10'h000);
		end
		wr(3'h6, 8'hff);
		rd(3'h6, v[7:0]);
		check(10'(v[7:0]), 10'h000);
		wr_cmpa(10'h25a);
		rd10(adr_ah, v);
		check(v, 10'h25a);
		// Lone low write waits for the high write
		wr(adr_ah - 3'h1, 8'h11);
		rd10(adr_ah, v);
		check(v, 10'h25a);
		wr(adr_dh - 3'h1, 8'h33);
		rd10(adr_dh, v);
		check(v, 10'h000);
		// Every count source in timer mode
		wr(adr_cb, 8'hc0);
		for (i = 0; i < 8; i++) begin
			wr(adr_ca, {1'b0, i[2:0], 4'h8});
			tick(256);
			wr(adr_ca, {1'b0, i[2:0], 4'h0});
			rd10(adr_dh, v);
			check(near(v, exp_src[i], 2), 10'h1);
			tick(20);
			rd10(adr_dh, w);
			check(w, v);
		end
		// Pause holds, resume continues, switch-on clears
		wr(adr_ca, 8'h18);
		tick(100);
		wr(adr_ca, 8'h98);
		rd10(adr_dh, v);
		tick(50);
		rd10(adr_dh, w);
		check(w, v);
		wr(adr_ca, 8'h18);
		tick(50);
		wr(adr_ca, 8'h10);
		rd10(adr_dh, w);
		check(near(w, v + 51, 3), 10'h1);
		wr(adr_ca, 8'h18);
		rd10(adr_dh, w);
		check(near(w, 5, 5), 10'h1);
		wr(adr_ca, 8'h10);
		// Output functions on compare A, clear on A
		wr_cmpa(10'h010);
		for (f = 0; f < 4; f++) begin
			wr(adr_cb, {2'b00, f[1:0], f == 1, f == 2, 2'b01});
			clr_flags();
			wr(adr_ca, 8'h18);
			tick(3);
			@(negedge sys_clk_in);
			check(10'(f == 1 || f == 2), 10'(pin));
			wait_flag(1'b0);
			tick(2);
			@(negedge sys_clk_in);
			check(10'(pin), 10'(f == 3));
			check(10'(flag_p), 10'h000);
			check(10'(flag_a), 10'h001);
			rd10(adr_dh, v);
			check(10'(v < 10'h010), 10'h001);
			wr(adr_ca, 8'h10);
		end
		// Period match only: pin and compare flag stay put
		wr_cmpa(10'h3f0);
		wr(adr_cb, 8'h20);
		clr_flags();
		wr(adr_ca, 8'h19);
		wait_flag(1'b1);
		check(near(10'(n), 128, 4), 10'h1);
		check({flag_a, pin}, 10'h000);
		wr(adr_ca, 8'h11);
		// Compare A of zero wraps at the top, no flag
		wr_cmpa(10'h000);
		wr(adr_cb, 8'h01);
		clr_flags();
		wr(adr_ca, 8'h18);
		tick(1100);
		wr(adr_ca, 8'h10);
		rd10(adr_dh, v);
		check(near(v, 77, 4), 10'h1);
		check(10'(flag_a), 10'h000);
		check(10'(flag_p), 10'h000);
		// PWM forced levels, active high
		for (f = 0; f < 2; f++) begin
			wr(adr_cb, {2'b10, f[1:0], 4'h8});
			wr(adr_ca, 8'h18);
			tick(5);
			@(negedge sys_clk_in);
			check(10'(pin), 10'(f));
			wr(adr_ca, 8'h10);
		end
		// Quarter duty with either role assignment
		for (f = 0; f < 2; f++) begin
			wr_cmpa(f ? 10'h200 : 10'h080);
			wr(adr_cb, {6'h2a, f[0], 1'b0});
			wr(adr_ca, f ? 8'h19 : 8'h1c);
			tick(8);
			meas_clr <= 1'b1;
			tick(1);
			meas_clr <= 1'b0;
			tick(1024);
			@(negedge sys_clk_in);
			check(near(high_cnt[9:0], 256, 8), 10'h1);
			wr(adr_ca, 8'h10);
		end
		results();
	end
endmodule : testbench
